// ---- rtl/adc_seq_top.sv ----
// APB register file for regular and injected conversion sequences, with the sequence walker
// assumes an APB master on pclk; the converter answers each conv_req with conv_done
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_top (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	output logic                  conv_req,
	output adc_seq_pkg::slot_t    conv_channel,
	output logic                  conv_injected,
	input  wire logic             conv_done
);
	import adc_seq_pkg::*;
`include "adc_seq_params.svh"

	seq_cfg_if   cfg ();
	slot_t       reg_slot [16];
	logic [3:0]  reg_len;
	slot_t       inj_slot [4];
	logic [1:0]  inj_len;
	logic        chan_err_flag;
	logic        wr_en;
	logic        setup;
	logic        mapped;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `OFF_REGULAR_13_TO_16) || (a == `OFF_REGULAR_7_TO_12)
			|| (a == `OFF_REGULAR_1_TO_6) || (a == `OFF_INJECTED_SEQUENCE)
			|| (a == `OFF_SEQ_CONTROL) || (a == `OFF_SEQ_STATUS);
	endfunction

	// packs six (or fewer) five-bit slots starting at a given slot number
	function automatic logic [29:0] pack_slots(input slot_t s [16], input int base);
		logic [29:0] w;
		w = 30'h0;
		for (int k = 0; k < 6; k++) begin
			if (base + k < 16) begin
				w[5*k +: 5] = s[base + k];
			end
		end
		pack_slots = w;
	endfunction

	assign setup  = psel && !penable;
	assign mapped = is_mapped(paddr);
	assign wr_en  = psel && penable && pwrite && mapped;
	// no wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ---------------------------------------------------------------
	// slot and length registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 16; k++) begin
				reg_slot[k] <= `RST_SLOT;
			end
			for (int k = 0; k < 4; k++) begin
				inj_slot[k] <= `RST_SLOT;
			end
			reg_len <= `RST_REGULAR_LEN;
			inj_len <= `RST_INJECTED_LEN;
		end else if (wr_en) begin
			case (paddr)
				`OFF_REGULAR_1_TO_6: begin
					for (int k = 0; k < 6; k++) begin
						reg_slot[k] <= pwdata[5*k +: 5];
					end
				end
				`OFF_REGULAR_7_TO_12: begin
					for (int k = 0; k < 6; k++) begin
						reg_slot[6 + k] <= pwdata[5*k +: 5];
					end
				end
				`OFF_REGULAR_13_TO_16: begin
					for (int k = 0; k < 4; k++) begin
						reg_slot[12 + k] <= pwdata[5*k +: 5];
					end
					reg_len <= pwdata[`REGULAR_LEN_LSB +: 4];
				end
				`OFF_INJECTED_SEQUENCE: begin
					for (int k = 0; k < 4; k++) begin
						inj_slot[k] <= pwdata[5*k +: 5];
					end
					inj_len <= pwdata[`INJECTED_LEN_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
	end

	// sticky out-of-range flag; a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_err_flag <= 1'b0;
		end else if (cfg.chan_err) begin
			chan_err_flag <= 1'b1;
		end else if (wr_en && paddr == `OFF_SEQ_STATUS && pwdata[`STAT_CHAN_ERR]) begin
			chan_err_flag <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RST_WORD;
		end else if (setup) begin
			case (paddr)
				`OFF_REGULAR_1_TO_6:    prdata <= {2'b00, pack_slots(reg_slot, 0)};
				`OFF_REGULAR_7_TO_12:   prdata <= {2'b00, pack_slots(reg_slot, 6)};
				`OFF_REGULAR_13_TO_16: begin
					prdata <= {8'h00, reg_len, reg_slot[15], reg_slot[14], reg_slot[13], reg_slot[12]};
				end
				`OFF_INJECTED_SEQUENCE: begin
					prdata <= {10'h000, inj_len, inj_slot[3], inj_slot[2], inj_slot[1], inj_slot[0]};
				end
				`OFF_SEQ_STATUS: begin
					prdata <= {23'h00_0000, chan_err_flag, cfg.slot_idx, 2'b00,
						cfg.inj_active, cfg.busy};
				end
				default:                prdata <= `RST_WORD;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// walker hookup
	// ---------------------------------------------------------------
	assign cfg.reg_slot  = reg_slot;
	assign cfg.inj_slot  = inj_slot;
	assign cfg.reg_len   = reg_len;
	assign cfg.inj_len   = inj_len;
	// starts are one-cycle pulses; ignored while a sequence is running
	assign cfg.start_reg = wr_en && paddr == `OFF_SEQ_CONTROL && pwdata[`CTRL_START_REGULAR];
	assign cfg.start_inj = wr_en && paddr == `OFF_SEQ_CONTROL && pwdata[`CTRL_START_INJECTED];

	seq_walker walker (
		.pclk          (pclk),
		.presetn       (presetn),
		.cfg           (cfg.walk),
		.conv_req      (conv_req),
		.conv_channel  (conv_channel),
		.conv_injected (conv_injected),
		.conv_done     (conv_done)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_WRITE_SLOTS_1_TO_6: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFF_REGULAR_1_TO_6) |=>
		(reg_slot[0] == $past(pwdata[4:0]) && reg_slot[5] == $past(pwdata[29:25])))
		else $error("slots one to six not stored at their bits");

	AST_WRITE_SLOTS_7_TO_12: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFF_REGULAR_7_TO_12) |=>
		(reg_slot[6] == $past(pwdata[4:0]) && reg_slot[11] == $past(pwdata[29:25])))
		else $error("slots seven to twelve not stored at their bits");

	AST_WRITE_INJECTED: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFF_INJECTED_SEQUENCE) |=>
		(inj_len == $past(pwdata[21:20]) && inj_slot[3] == $past(pwdata[19:15])))
		else $error("injected length or slot four not stored");

	AST_INJ_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && paddr == `OFF_INJECTED_SEQUENCE) |=> prdata[31:22] == 10'h000)
		else $error("injected register reserved bits read nonzero");

	AST_READBACK_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && paddr == `OFF_REGULAR_13_TO_16) |=> prdata[23:20] == $past(reg_len))
		else $error("regular length does not read back");

	AST_UNMAPPED_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable) |-> (pready && pslverr == !is_mapped(paddr)))
		else $error("unmapped access not answered with an error");

	AST_WRITE_REGULAR_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && paddr == `OFF_REGULAR_13_TO_16) |=>
		(reg_len == $past(pwdata[23:20]) && reg_slot[15] == $past(pwdata[19:15])))
		else $error("regular length or slot sixteen not stored");

	AST_READBACK_SLOTS_1_TO_6: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && paddr == `OFF_REGULAR_1_TO_6) |=>
		(prdata[31:30] == 2'b00 && prdata[29:25] == $past(reg_slot[5])))
		else $error("slots one to six do not read back at their bits");

	AST_READBACK_SLOTS_7_TO_12: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && paddr == `OFF_REGULAR_7_TO_12) |=>
		(prdata[31:30] == 2'b00 && prdata[4:0] == $past(reg_slot[6])))
		else $error("slots seven to twelve do not read back at their bits");

	// the flag must catch every skipped slot, even one cleared in the same cycle
	AST_CHAN_ERR_SET: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.chan_err |=> chan_err_flag)
		else $error("out-of-range channel not flagged");
endmodule
`default_nettype wire

// ---- inc/adc_seq_params.svh ----
// register offsets, field positions and reset values of the sequence configuration block
// assumes a 12-bit byte address on the register bus
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ---------------------------------------------------------------
// offsets
// ---------------------------------------------------------------
`define OFF_REGULAR_13_TO_16   12'h030
`define OFF_REGULAR_7_TO_12    12'h034
`define OFF_REGULAR_1_TO_6     12'h038
`define OFF_INJECTED_SEQUENCE  12'h03C
`define OFF_SEQ_CONTROL        12'h058
`define OFF_SEQ_STATUS         12'h05C

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define SLOT_W                 5
`define MAX_CHANNEL            5'h17
`define REGULAR_LEN_LSB        20
`define INJECTED_LEN_LSB       20
`define CTRL_START_REGULAR     0
`define CTRL_START_INJECTED    1
`define STAT_BUSY              0
`define STAT_INJ_ACTIVE        1
`define STAT_SLOT_LSB          4
`define STAT_CHAN_ERR          8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_SLOT               5'h00
`define RST_REGULAR_LEN        4'h0
`define RST_INJECTED_LEN       2'h0
`define RST_WORD               32'h0000_0000

`endif

// ---- inc/adc_seq_pkg.sv ----
// types shared by the sequence configuration block
// assumes nothing beyond a SystemVerilog compiler
package adc_seq_pkg;
	typedef logic [4:0] slot_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT  = 3'b100
	} walk_state_t;
endpackage

// ---- inc/seq_cfg_if.sv ----
// carries programmed slots and status between register file and sequence walker
// assumes both ends share pclk
`timescale 1ns/1ps
`default_nettype none
interface seq_cfg_if;
	import adc_seq_pkg::*;
	slot_t       reg_slot [16];
	logic [3:0]  reg_len;
	slot_t       inj_slot [4];
	logic [1:0]  inj_len;
	logic        start_reg;
	logic        start_inj;
	logic        busy;
	logic        inj_active;
	logic [3:0]  slot_idx;
	logic        chan_err;
	modport ctrl (output reg_slot, reg_len, inj_slot, inj_len, start_reg, start_inj,
		input busy, inj_active, slot_idx, chan_err);
	modport walk (input reg_slot, reg_len, inj_slot, inj_len, start_reg, start_inj,
		output busy, inj_active, slot_idx, chan_err);
endinterface
`default_nettype wire

// ---- rtl/seq_walker.sv ----
// steps through the regular or injected slot list and asks the converter for each channel up to 23, skipping out-of-range ones
// assumes the converter answers each request with conv_done, one clock, pclk domain
`timescale 1ns/1ps
`default_nettype none
module seq_walker (
	input  wire logic             pclk,
	input  wire logic             presetn,
	seq_cfg_if.walk               cfg,
	output logic                  conv_req,
	output adc_seq_pkg::slot_t    conv_channel,
	output logic                  conv_injected,
	input  wire logic             conv_done
);
	import adc_seq_pkg::*;
`include "adc_seq_params.svh"

	walk_state_t state;
	logic [3:0]  idx;
	logic [3:0]  last;
	logic        inj;
	slot_t       cur_chan;
	logic        cur_ok;
	logic        at_end;
	logic        advance;

	// ---------------------------------------------------------------
	// slot selection
	// ---------------------------------------------------------------
	function automatic logic chan_ok(input slot_t ch);
		chan_ok = (ch <= `MAX_CHANNEL);
	endfunction

	assign cur_chan = inj ? cfg.inj_slot[idx[1:0]] : cfg.reg_slot[idx];
	assign cur_ok   = chan_ok(cur_chan);
	assign at_end   = (idx == last);
	// an out-of-range channel is skipped rather than sent to the converter
	assign advance  = ((state == ST_ISSUE) && !cur_ok) || ((state == ST_WAIT) && conv_done);

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			idx   <= 4'h0;
			last  <= 4'h0;
			inj   <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cfg.start_inj) begin
						idx   <= {2'b00, 2'd3 - cfg.inj_len};
						last  <= 4'h3;
						inj   <= 1'b1;
						state <= ST_ISSUE;
					end else if (cfg.start_reg) begin
						idx   <= 4'h0;
						last  <= cfg.reg_len;
						inj   <= 1'b0;
						state <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (cur_ok) begin
						state <= ST_WAIT;
					end else if (at_end) begin
						state <= ST_IDLE;
					end else begin
						idx <= idx + 4'h1;
					end
				end
				ST_WAIT: begin
					if (advance) begin
						if (at_end) begin
							state <= ST_IDLE;
						end else begin
							idx   <= idx + 4'h1;
							state <= ST_ISSUE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_req      <= 1'b0;
			conv_channel  <= `RST_SLOT;
			conv_injected <= 1'b0;
		end else begin
			conv_req <= (state == ST_ISSUE) && cur_ok;
			if ((state == ST_ISSUE) && cur_ok) begin
				conv_channel  <= cur_chan;
				conv_injected <= inj;
			end
		end
	end

	assign cfg.busy       = (state != ST_IDLE);
	assign cfg.inj_active = inj && (state != ST_IDLE);
	assign cfg.slot_idx   = idx;
	assign cfg.chan_err   = (state == ST_ISSUE) && !cur_ok;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_REQ_CHANNEL_VALID: assert property (@(posedge pclk) disable iff (!presetn)
		conv_req |-> conv_channel <= `MAX_CHANNEL)
		else $error("converter asked for a channel above 23");

	AST_INJ_FIRST_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_IDLE && cfg.start_inj) |=> (idx == 4'(3 - $past(cfg.inj_len)) && last == 4'h3))
		else $error("injected sequence did not start at slot four minus length");

	AST_REG_FIRST_SLOT: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_IDLE && cfg.start_reg && !cfg.start_inj) |=> (idx == 4'h0 && !inj))
		else $error("regular sequence did not start at slot one");

	AST_REG_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_IDLE && cfg.start_reg && !cfg.start_inj) |=> last == $past(cfg.reg_len))
		else $error("regular sequence length not taken from the length field");

	AST_ASCENDING: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_WAIT && conv_done && !at_end) |=> (idx == 4'($past(idx) + 1) && state == ST_ISSUE))
		else $error("sequence did not move to the next slot");

	AST_REQ_AFTER_ISSUE: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ST_ISSUE && cur_ok) |=> (conv_req && conv_channel == $past(cur_chan)) ##1 !conv_req)
		else $error("request not a single pulse with the slot channel");
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the conversion sequence register block
// assumes apb master and converter are both played by this bench on pclk
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_params.svh"
module testbench;
	import adc_seq_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        conv_req;
	slot_t       conv_channel;
	logic        conv_injected;
	logic        conv_done;
	int          num_errors;
	int          n_checks;
	logic [31:0] rd;
	logic        err;
	logic [4:0]  ch [1:16];
	logic [4:0]  inj_ch [1:4];
	slot_t       exp_q [$];

	adc_seq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_req(conv_req), .conv_channel(conv_channel),
		.conv_injected(conv_injected), .conv_done(conv_done));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp,
		input logic exp_err);
		apb(1'b0, a, 32'h0000_0000);
		check(rd & mask, exp);
		check({31'h0, err}, {31'h0, exp_err});
	endtask

	function automatic logic [29:0] pack6(input int base);
		logic [29:0] w;
		for (int k = 0; k < 6; k++) w[k*5 +: 5] = ch[base+k];
		return w;
	endfunction

	// converter side: reads the status after each request, then answers with a one-cycle conv_done, then checks for strays
	task run_seq(input logic inj);
		int n;
		for (int i = 0; i < exp_q.size(); i++) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (conv_req !== 1'b1 && n < 40);
			check({31'h0, conv_req}, 32'h0000_0001);
			check({27'h0, conv_channel}, {27'h0, exp_q[i]});
			check({31'h0, conv_injected}, {31'h0, inj});
			rd_chk(`OFF_SEQ_STATUS, 32'h0000_0003, {30'h0, inj, 1'b1}, 1'b0);
			conv_done <= 1'b1;
			@(posedge pclk);
			conv_done <= 1'b0;
		end
		n = 0;
		repeat (12) begin
			@(posedge pclk);
			if (conv_req === 1'b1) n++;
		end
		check(32'(n), 32'h0000_0000);
		rd_chk(`OFF_SEQ_STATUS, 32'h0000_0003, 32'h0000_0000, 1'b0);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_reset;
		rd_chk(`OFF_REGULAR_13_TO_16, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		rd_chk(`OFF_REGULAR_7_TO_12, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		rd_chk(`OFF_REGULAR_1_TO_6, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		rd_chk(`OFF_INJECTED_SEQUENCE, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
	endtask

	// reserved bits must read back zero after an all-ones write
	task t_fields;
		logic [11:0] offs [4];
		logic [31:0] msk [4];
		offs = '{`OFF_REGULAR_13_TO_16, `OFF_REGULAR_7_TO_12, `OFF_REGULAR_1_TO_6,
			`OFF_INJECTED_SEQUENCE};
		msk = '{32'h00FF_FFFF, 32'h3FFF_FFFF, 32'h3FFF_FFFF, 32'h003F_FFFF};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, offs[i], 32'hFFFF_FFFF);
			rd_chk(offs[i], 32'hFFFF_FFFF, msk[i], 1'b0);
			apb(1'b1, offs[i], 32'h0000_0000);
			rd_chk(offs[i], 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
		end
		rd_chk(12'h100, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
	endtask

	// longest regular sequence: every slot position gets a distinct channel
	task t_regular_full;
		for (int i = 1; i <= 16; i++) ch[i] = 5'((i * 7) % 24);
		apb(1'b1, `OFF_REGULAR_1_TO_6, {2'b00, pack6(1)});
		apb(1'b1, `OFF_REGULAR_7_TO_12, {2'b00, pack6(7)});
		apb(1'b1, `OFF_REGULAR_13_TO_16, {8'h00, 4'hF, ch[16], ch[15], ch[14], ch[13]});
		exp_q = {};
		for (int i = 1; i <= 16; i++) exp_q.push_back(ch[i]);
		apb(1'b1, `OFF_SEQ_CONTROL, 32'h0000_0001);
		run_seq(1'b0);
	endtask

	// out-of-range channel in slot two is skipped and flagged
	task t_regular_skip;
		ch[2] = 5'h18;
		apb(1'b1, `OFF_REGULAR_1_TO_6, {2'b00, pack6(1)});
		apb(1'b1, `OFF_REGULAR_13_TO_16, {8'h00, 4'h2, 20'h0_0000});
		exp_q = {ch[1], ch[3]};
		apb(1'b1, `OFF_SEQ_CONTROL, 32'h0000_0001);
		run_seq(1'b0);
		rd_chk(`OFF_SEQ_STATUS, 32'h0000_0100, 32'h0000_0100, 1'b0);
		apb(1'b1, `OFF_SEQ_STATUS, 32'h0000_0100);
		rd_chk(`OFF_SEQ_STATUS, 32'h0000_0100, 32'h0000_0000, 1'b0);
	endtask

	// short injected sequences start at slot four minus the length field
	task t_injected;
		inj_ch = '{5'd2, 5'd7, 5'd3, 5'd3};
		for (int jl = 0; jl < 4; jl++) begin
			apb(1'b1, `OFF_INJECTED_SEQUENCE,
				{10'h000, 2'(jl), inj_ch[4], inj_ch[3], inj_ch[2], inj_ch[1]});
			exp_q = {};
			for (int s = 4 - jl; s <= 4; s++) exp_q.push_back(inj_ch[s]);
			// both start bits on the last pass: the injected sequence must win
			apb(1'b1, `OFF_SEQ_CONTROL, (jl == 3) ? 32'h0000_0003 : 32'h0000_0002);
			run_seq(1'b1);
		end
	endtask

	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	task give_verdict;
		if (num_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// whole run is well under 3000 cycles, so 20000 means a hang
	initial begin
		#(20 * 20000);
		num_errors++;
		give_verdict();
	end

	initial begin
		num_errors = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		conv_done = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_regular_full();
		t_regular_skip();
		t_injected();
		give_verdict();
	end
endmodule
`default_nettype wire
